// File: rtl/flr_pkg.sv
package flr_pkg;

    // Command codes
    localparam logic [7:0] CMD_OC_FAULT_LEVEL  = 8'h46;
    localparam logic [7:0] CMD_OC_FAULT_ACTION = 8'h47;
    localparam logic [7:0] CMD_OC_WARN_LEVEL   = 8'h4a;
    localparam logic [7:0] CMD_OT_FAULT_LEVEL  = 8'h4f;
    localparam logic [7:0] CMD_OT_FAULT_ACTION = 8'h50;
    localparam logic [7:0] CMD_OT_WARN_LEVEL   = 8'h51;
    localparam logic [7:0] CMD_VIN_OV_LEVEL    = 8'h55;
    localparam logic [7:0] CMD_TURN_ON_DELAY   = 8'h60;
    localparam logic [7:0] CMD_RISE_TIME       = 8'h61;
    localparam logic [7:0] CMD_STATUS_WORD     = 8'h79;
    localparam logic [7:0] CMD_VOUT_STATUS     = 8'h7a;
    localparam logic [7:0] CMD_IOUT_STATUS     = 8'h7b;

    // Accepted ranges, plain integer units
    localparam logic [15:0] OC_FAULT_MIN  = 16'h0022;
    localparam logic [15:0] OC_FAULT_MAX  = 16'h0064;
    localparam logic [15:0] OC_WARN_MIN   = 16'h0019;
    localparam logic [15:0] OC_WARN_MAX   = 16'h0082;
    localparam logic [15:0] OT_FAULT_MIN  = 16'h0019;
    localparam logic [15:0] OT_FAULT_MAX  = 16'h008c;
    localparam logic [15:0] OT_WARN_MIN   = 16'h0019;
    localparam logic [15:0] OT_WARN_MAX   = 16'h007d;
    localparam logic [15:0] VIN_OV_MIN    = 16'h0030;
    localparam logic [15:0] VIN_OV_MAX    = 16'h005a;
    localparam logic [15:0] ON_DLY_MIN    = 16'h0000;
    localparam logic [15:0] ON_DLY_MAX    = 16'h01f4;
    localparam logic [15:0] RISE_MIN      = 16'h000c;
    localparam logic [15:0] RISE_MAX      = 16'h01f4;

    // Values after reset
    localparam logic [15:0] OC_FAULT_RST  = 16'h0064;
    localparam logic [15:0] OC_WARN_RST   = 16'h005a;
    localparam logic [15:0] OT_FAULT_RST  = 16'h007d;
    localparam logic [15:0] OT_WARN_RST   = 16'h006e;
    localparam logic [15:0] VIN_OV_RST    = 16'h0041;
    localparam logic [15:0] ON_DLY_RST    = 16'h0000;
    localparam logic [15:0] RISE_RST      = 16'h000c;
    localparam logic [7:0]  OC_ACTION_RST = 8'hf8;
    localparam logic [7:0]  OT_ACTION_RST = 8'hb8;

    // Fault action byte layout
    localparam int         RETRY_LSB  = 3;
    localparam int         RESP_LSB   = 6;
    localparam logic [2:0] RETRY_OFF  = 3'h0;
    localparam logic [2:0] RETRY_CONT = 3'h7;
    localparam logic [1:0] RESP_OC    = 2'h3;
    localparam logic [1:0] RESP_OT    = 2'h2;
    localparam logic [2:0] DELAY_NONE = 3'h0;

    // Detailed status bits
    localparam int        VOUT_OV_BIT  = 7;
    localparam int        IOUT_OC_BIT  = 7;
    localparam int        IOUT_WRN_BIT = 5;
    localparam logic [7:0] STATUS_RST  = 8'h00;

    typedef enum logic [1:0] {
        FLR_TRIP_RUN     = 2'b00,
        FLR_TRIP_RESTART = 2'b01,
        FLR_TRIP_LATCHED = 2'b10
    } flr_trip_e;

    function automatic logic flr_in_range(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    function automatic logic flr_retry_ok(input logic [2:0] r);
        return (r == RETRY_OFF) || (r == RETRY_CONT);
    endfunction

endpackage

// File: rtl/flr_write_check.sv
`timescale 1ns/1ps
module flr_write_check (
    input  wire logic [7:0]  cmd_in,            // Command code of the write
    input  wire logic [15:0] data_in,           // Proposed value
    input  wire logic [15:0] oc_fault_level_in, // Stored overcurrent fault level
    input  wire logic [15:0] oc_warn_level_in,  // Stored overcurrent warning level
    input  wire logic [15:0] ot_fault_level_in, // Stored overheat fault level
    input  wire logic [15:0] ot_warn_level_in,  // Stored overheat warning level
    output logic             known_out,         // Command is mapped
    output logic             legal_out,         // Value passes range and ordering
    output logic             lockable_out       // Command obeys write protect
);
    import flr_pkg::*;

    always_comb begin
        known_out    = 1'b1;
        legal_out    = 1'b0;
        lockable_out = 1'b1;
        case (cmd_in)
            CMD_OC_FAULT_LEVEL: legal_out = flr_in_range(data_in, OC_FAULT_MIN, OC_FAULT_MAX)
                                    && (data_in > oc_warn_level_in);       // RQ18
            CMD_OC_WARN_LEVEL:  legal_out = flr_in_range(data_in, OC_WARN_MIN, OC_WARN_MAX)
                                    && (data_in < oc_fault_level_in);      // RQ8
            CMD_OT_FAULT_LEVEL: legal_out = flr_in_range(data_in, OT_FAULT_MIN, OT_FAULT_MAX)
                                    && (data_in > ot_warn_level_in);       // RQ9
            CMD_OT_WARN_LEVEL:  legal_out = flr_in_range(data_in, OT_WARN_MIN, OT_WARN_MAX)
                                    && (data_in < ot_fault_level_in);      // RQ10
            CMD_VIN_OV_LEVEL:   legal_out = flr_in_range(data_in, VIN_OV_MIN, VIN_OV_MAX); // RQ11
            CMD_TURN_ON_DELAY:  legal_out = flr_in_range(data_in, ON_DLY_MIN,
                                                         ON_DLY_MAX);      // RQ12
            CMD_RISE_TIME:      legal_out = flr_in_range(data_in, RISE_MIN, RISE_MAX); // RQ12
            CMD_OC_FAULT_ACTION,
            CMD_OT_FAULT_ACTION: legal_out = flr_retry_ok(data_in[RETRY_LSB +: 3]); // RQ2
            CMD_VOUT_STATUS,
            CMD_IOUT_STATUS: begin
                legal_out    = 1'b1;
                lockable_out = 1'b0;
            end
            CMD_STATUS_WORD: lockable_out = 1'b0;
            default: begin
                known_out    = 1'b0;
                lockable_out = 1'b0;
            end
        endcase
    end

endmodule // flr_write_check

// File: rtl/flr_regs.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Overcurrent response field is fixed at 11: shut down, then follow retry.
// [RQ2] Retry codes 000 (stay off) and 111 (restart while fault persists) only.
// [RQ3] Delay field fixed at zero; shutdown acts with no delay.
// [RQ4] Overcurrent default: shut down, restart continuously, no delay.
// [RQ5] Overheat response field is fixed at 10: shut down, then follow retry.
// [RQ6] Overheat byte: delay bits 2:0 read-only, retry 5:3 writable, response 7:6 fixed.
// [RQ7] Overheat byte resets to response 10, retry 111, delay 000.
// [RQ8] Overcurrent warning accepted 25 to 130 and below the fault level.
// [RQ9] Overheat fault accepted 25 to 140 and above the warning level.
// [RQ10] Overheat warning accepted 25 to 125 and below the fault level.
// [RQ11] Input overvoltage level holds 48 to 90 and obeys write protect.
// [RQ12] Turn-on delay spans 0 to 500, rise time 12 to 500.
// [RQ13] Status word read-only; high byte bits 15, 14, 13, 11 only.
// [RQ14] Low byte bits 6 to 1 report off, faults, temperature, communication.
// [RQ15] Output-voltage status keeps only bit 7; bits clear by writing one.
// [RQ16] Output-current status keeps bits 7 and 5; bits clear by writing one.
// [RQ17] Write protect high blocks writes to threshold and response commands.
// [RQ18] Overcurrent fault accepted 34 to 100 and above the warning level.
// [RQ19] Summary bits follow their detailed bytes; unsupported bits read zero.
// [RQ20] Out-of-range or misordered writes leave the value and flag invalid data; locked writes under write protect are not flagged.
module flr_regs (
    input  wire logic        clk_sys_in,                    // System clock, 100 MHz
    input  wire logic        rst_b_in,                      // Synchronous reset, active low
    input  wire logic        clk_en_in,                     // Freezes all state when low
    input  wire logic [7:0]  cmd_in,                        // Command code
    input  wire logic        wr_in,                         // Write strobe, one cycle
    input  wire logic [15:0] wr_data_in,                    // Write data
    input  wire logic        rd_in,                         // Read strobe, one cycle
    input  wire logic        write_protect_enable_in,       // Lockout bit of device type reg
    input  wire logic        vout_ov_fault_in,              // Output overvoltage event
    input  wire logic        iout_oc_fault_in,              // Output overcurrent fault level
    input  wire logic        iout_oc_warn_in,               // Output overcurrent warning
    input  wire logic        ot_fault_in,                   // Overheat fault level
    input  wire logic        input_fault_in,                // Any input status bit
    input  wire logic        vin_uv_fault_in,               // Input undervoltage fault
    input  wire logic        temp_fault_in,                 // Any temperature status bit
    input  wire logic        communication_fault_summary_in, // Any communication status bit
    input  wire logic        power_not_good_in,             // Power not good
    input  wire logic        output_off_in,                 // Output commanded or held off
    output logic      [15:0] rd_data_out,                   // Read data
    output logic             rd_valid_out,                  // Read data valid, one cycle
    output logic             invalid_data_out,              // Rejected write value, pulse
    output logic             invalid_cmd_out,               // Unmapped command, pulse
    output logic             oc_shutdown_out,               // Overcurrent shutdown request
    output logic             ot_shutdown_out,               // Overheat shutdown request
    output logic      [15:0] oc_fault_level_out,            // Overcurrent fault level
    output logic      [15:0] oc_warn_level_out,             // Overcurrent warning level
    output logic      [15:0] ot_fault_level_out,            // Overheat fault level
    output logic      [15:0] ot_warn_level_out,             // Overheat warning level
    output logic      [15:0] vin_ov_level_out,              // Input overvoltage level
    output logic      [15:0] turn_on_delay_out,             // Turn-on delay setting
    output logic      [15:0] rise_time_out                  // Output rise time setting
);
    import flr_pkg::*;

    logic [15:0] oc_fault_level_reg;
    logic [15:0] oc_warn_level_reg;
    logic [15:0] ot_fault_level_reg;
    logic [15:0] ot_warn_level_reg;
    logic [15:0] vin_ov_level_reg;
    logic [15:0] turn_on_delay_reg;
    logic [15:0] rise_time_reg;
    logic [2:0]  oc_retry_reg;
    logic [2:0]  ot_retry_reg;
    logic [7:0]  vout_status_reg;
    logic [7:0]  iout_status_reg;
    flr_trip_e   oc_trip_reg;
    flr_trip_e   oc_trip_next;
    flr_trip_e   ot_trip_reg;
    flr_trip_e   ot_trip_next;
    logic        known;
    logic        legal;
    logic        lockable;
    logic        wr_commit;
    logic [7:0]  oc_action;
    logic [7:0]  ot_action;
    logic [15:0] status_word;
    logic [15:0] rd_mux;
    logic [7:0]  vout_clr;
    logic [7:0]  iout_clr;

    flr_write_check u_check (
        .cmd_in            (cmd_in),
        .data_in           (wr_data_in),
        .oc_fault_level_in (oc_fault_level_reg),
        .oc_warn_level_in  (oc_warn_level_reg),
        .ot_fault_level_in (ot_fault_level_reg),
        .ot_warn_level_in  (ot_warn_level_reg),
        .known_out         (known),
        .legal_out         (legal),
        .lockable_out      (lockable)
    );

    // Locked writes are dropped silently; nothing in the value is wrong
    assign wr_commit = wr_in && known && legal && !(lockable && write_protect_enable_in); // RQ17

    // Only the retry field is stored; response and delay are fixed
    assign oc_action = {RESP_OC, oc_retry_reg, DELAY_NONE}; // RQ1 RQ3
    assign ot_action = {RESP_OT, ot_retry_reg, DELAY_NONE}; // RQ5 RQ6

    always_comb begin
        status_word     = 16'h0000; // RQ19
        status_word[15] = |vout_status_reg; // RQ13 RQ19
        status_word[14] = |iout_status_reg; // RQ13 RQ19
        status_word[13] = input_fault_in; // RQ13
        status_word[11] = power_not_good_in; // RQ13
        status_word[6]  = output_off_in; // RQ14
        status_word[5]  = vout_status_reg[VOUT_OV_BIT]; // RQ14
        status_word[4]  = iout_status_reg[IOUT_OC_BIT]; // RQ14
        status_word[3]  = vin_uv_fault_in; // RQ14
        status_word[2]  = temp_fault_in; // RQ14
        status_word[1]  = communication_fault_summary_in; // RQ14
    end

    always_comb begin
        if (cmd_in == CMD_OC_FAULT_LEVEL) begin
            rd_mux = oc_fault_level_reg;
        end else if (cmd_in == CMD_OC_FAULT_ACTION) begin
            rd_mux = {8'h00, oc_action};
        end else if (cmd_in == CMD_OC_WARN_LEVEL) begin
            rd_mux = oc_warn_level_reg;
        end else if (cmd_in == CMD_OT_FAULT_LEVEL) begin
            rd_mux = ot_fault_level_reg;
        end else if (cmd_in == CMD_OT_FAULT_ACTION) begin
            rd_mux = {8'h00, ot_action};
        end else if (cmd_in == CMD_OT_WARN_LEVEL) begin
            rd_mux = ot_warn_level_reg;
        end else if (cmd_in == CMD_VIN_OV_LEVEL) begin
            rd_mux = vin_ov_level_reg;
        end else if (cmd_in == CMD_TURN_ON_DELAY) begin
            rd_mux = turn_on_delay_reg;
        end else if (cmd_in == CMD_RISE_TIME) begin
            rd_mux = rise_time_reg;
        end else if (cmd_in == CMD_STATUS_WORD) begin
            rd_mux = status_word;
        end else if (cmd_in == CMD_VOUT_STATUS) begin
            rd_mux = {8'h00, vout_status_reg};
        end else if (cmd_in == CMD_IOUT_STATUS) begin
            rd_mux = {8'h00, iout_status_reg};
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Threshold and response storage
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            oc_fault_level_reg <= OC_FAULT_RST;
            oc_warn_level_reg  <= OC_WARN_RST;
            ot_fault_level_reg <= OT_FAULT_RST;
            ot_warn_level_reg  <= OT_WARN_RST;
            vin_ov_level_reg   <= VIN_OV_RST;
            turn_on_delay_reg  <= ON_DLY_RST;
            rise_time_reg      <= RISE_RST;
            oc_retry_reg       <= OC_ACTION_RST[RETRY_LSB +: 3]; // RQ4
            ot_retry_reg       <= OT_ACTION_RST[RETRY_LSB +: 3]; // RQ7
        end else if (clk_en_in && wr_commit) begin
            case (cmd_in)
                CMD_OC_FAULT_LEVEL:  oc_fault_level_reg <= wr_data_in; // RQ18
                CMD_OC_WARN_LEVEL:   oc_warn_level_reg  <= wr_data_in; // RQ8
                CMD_OT_FAULT_LEVEL:  ot_fault_level_reg <= wr_data_in; // RQ9
                CMD_OT_WARN_LEVEL:   ot_warn_level_reg  <= wr_data_in; // RQ10
                CMD_VIN_OV_LEVEL:    vin_ov_level_reg   <= wr_data_in; // RQ11
                CMD_TURN_ON_DELAY:   turn_on_delay_reg  <= wr_data_in; // RQ12
                CMD_RISE_TIME:       rise_time_reg      <= wr_data_in; // RQ12
                CMD_OC_FAULT_ACTION: oc_retry_reg <= wr_data_in[RETRY_LSB +: 3]; // RQ2
                CMD_OT_FAULT_ACTION: ot_retry_reg <= wr_data_in[RETRY_LSB +: 3]; // RQ6
                default: ;
            endcase
        end
    end

    // Write-one-to-clear masks; a set in the same cycle still wins
    assign vout_clr = (clk_en_in && wr_commit && cmd_in == CMD_VOUT_STATUS) ?
                      wr_data_in[7:0] : 8'h00;
    assign iout_clr = (clk_en_in && wr_commit && cmd_in == CMD_IOUT_STATUS) ?
                      wr_data_in[7:0] : 8'h00;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            vout_status_reg <= STATUS_RST;
        end else if (clk_en_in) begin
            vout_status_reg <= STATUS_RST;
            vout_status_reg[VOUT_OV_BIT] <= vout_ov_fault_in
                || (vout_status_reg[VOUT_OV_BIT] && !vout_clr[VOUT_OV_BIT]); // RQ15
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            iout_status_reg <= STATUS_RST;
        end else if (clk_en_in) begin
            iout_status_reg <= STATUS_RST;
            iout_status_reg[IOUT_OC_BIT] <= iout_oc_fault_in
                || (iout_status_reg[IOUT_OC_BIT] && !iout_clr[IOUT_OC_BIT]); // RQ16
            iout_status_reg[IOUT_WRN_BIT] <= iout_oc_warn_in
                || (iout_status_reg[IOUT_WRN_BIT] && !iout_clr[IOUT_WRN_BIT]); // RQ16
        end
    end

    // Restart mode drops back to run once the fault is gone; latched waits for off
    function automatic flr_trip_e trip_step(input flr_trip_e cur, input logic fault,
                                            input logic [2:0] retry, input logic off);
        flr_trip_e nxt;
        nxt = cur;
        case (cur)
            FLR_TRIP_RUN: begin
                if (fault) begin
                    nxt = (retry == RETRY_CONT) ? FLR_TRIP_RESTART : FLR_TRIP_LATCHED;
                end
            end
            FLR_TRIP_RESTART: begin
                if (!fault) begin
                    nxt = FLR_TRIP_RUN;
                end
            end
            FLR_TRIP_LATCHED: begin
                if (off && !fault) begin
                    nxt = FLR_TRIP_RUN;
                end
            end
            default: nxt = FLR_TRIP_RUN;
        endcase
        return nxt;
    endfunction

    assign oc_trip_next = trip_step(oc_trip_reg, iout_oc_fault_in, oc_retry_reg,
                                    output_off_in); // RQ1 RQ2
    assign ot_trip_next = trip_step(ot_trip_reg, ot_fault_in, ot_retry_reg,
                                    output_off_in); // RQ5 RQ2

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            oc_trip_reg     <= FLR_TRIP_RUN;
            ot_trip_reg     <= FLR_TRIP_RUN;
            oc_shutdown_out <= 1'b0;
            ot_shutdown_out <= 1'b0;
        end else if (clk_en_in) begin
            oc_trip_reg     <= oc_trip_next;
            ot_trip_reg     <= ot_trip_next;
            oc_shutdown_out <= (oc_trip_next != FLR_TRIP_RUN); // RQ3 RQ4
            ot_shutdown_out <= (ot_trip_next != FLR_TRIP_RUN); // RQ3
        end
    end

    // Read port and error pulses
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rd_data_out      <= 16'h0000;
            rd_valid_out     <= 1'b0;
            invalid_data_out <= 1'b0;
            invalid_cmd_out  <= 1'b0;
        end else if (clk_en_in) begin
            rd_valid_out     <= rd_in;
            rd_data_out      <= rd_in ? rd_mux : 16'h0000;
            invalid_data_out <= wr_in && known && !legal
                                && !(lockable && write_protect_enable_in); // RQ20
            invalid_cmd_out  <= (wr_in || rd_in) && !known;
        end
    end

    assign oc_fault_level_out = oc_fault_level_reg;
    assign oc_warn_level_out  = oc_warn_level_reg;
    assign ot_fault_level_out = ot_fault_level_reg;
    assign ot_warn_level_out  = ot_warn_level_reg;
    assign vin_ov_level_out   = vin_ov_level_reg;
    assign turn_on_delay_out  = turn_on_delay_reg;
    assign rise_time_out      = rise_time_reg;

    default clocking cb @(posedge clk_sys_in iff clk_en_in);
    endclocking
    default disable iff (!rst_b_in);

    a_lock_blocks_write: assert property ( // RQ17
        wr_in && write_protect_enable_in && cmd_in == CMD_VIN_OV_LEVEL
        |=> vin_ov_level_reg == $past(vin_ov_level_reg))
        else $error("locked write changed the overvoltage level");

    a_lock_no_flag: assert property ( // RQ17
        wr_in && write_protect_enable_in && cmd_in == CMD_VIN_OV_LEVEL |=> !invalid_data_out)
        else $error("locked write raised invalid data");

    a_reject_flags: assert property ( // RQ20
        wr_in && !write_protect_enable_in && cmd_in == CMD_OT_WARN_LEVEL
        && wr_data_in > OT_WARN_MAX
        |=> invalid_data_out && ot_warn_level_reg == $past(ot_warn_level_reg))
        else $error("out-of-range write not rejected");

    a_oc_order_kept: assert property ( // RQ8
        oc_warn_level_reg < oc_fault_level_reg)
        else $error("overcurrent warning not below fault level");

    a_ot_order_kept: assert property ( // RQ9
        ot_warn_level_reg < ot_fault_level_reg)
        else $error("overheat warning not below fault level");

    a_action_fixed: assert property ( // RQ1
        rd_in && (cmd_in == CMD_OC_FAULT_ACTION || cmd_in == CMD_OT_FAULT_ACTION)
        |=> rd_data_out[7] && rd_data_out[2:0] == DELAY_NONE && rd_data_out[15:8] == 8'h00)
        else $error("fixed action field changed");

    a_retry_legal: assert property ( // RQ2
        flr_retry_ok(oc_retry_reg) && flr_retry_ok(ot_retry_reg))
        else $error("illegal retry code stored");

    a_vin_ton_range: assert property ( // RQ11
        flr_in_range(vin_ov_level_reg, VIN_OV_MIN, VIN_OV_MAX)
        && flr_in_range(turn_on_delay_reg, ON_DLY_MIN, ON_DLY_MAX)
        && flr_in_range(rise_time_reg, RISE_MIN, RISE_MAX))
        else $error("level outside accepted range");

    a_vout_sticky: assert property ( // RQ15
        vout_ov_fault_in |=> vout_status_reg[VOUT_OV_BIT] && vout_status_reg[6:0] == 7'h00)
        else $error("overvoltage status not captured");

    a_warn_clear: assert property ( // RQ16
        iout_status_reg[IOUT_WRN_BIT] && !iout_oc_warn_in && wr_in
        && cmd_in == CMD_IOUT_STATUS && wr_data_in[IOUT_WRN_BIT]
        |=> !iout_status_reg[IOUT_WRN_BIT])
        else $error("warning status not cleared by write");

    a_summary_read: assert property ( // RQ19
        rd_in && cmd_in == CMD_STATUS_WORD
        |=> rd_valid_out && rd_data_out[4] == $past(iout_status_reg[IOUT_OC_BIT])
            && rd_data_out[12] == 1'b0 && rd_data_out[0] == 1'b0)
        else $error("summary word does not follow status bytes");

    a_oc_shutdown: assert property ( // RQ4
        iout_oc_fault_in |=> oc_shutdown_out)
        else $error("overcurrent did not shut down with no delay");

    a_ot_shutdown: assert property ( // RQ5
        ot_fault_in |=> ot_shutdown_out)
        else $error("overheat did not shut down with no delay");

    a_restart_release: assert property ( // RQ2
        ot_trip_reg == FLR_TRIP_RESTART && !ot_fault_in |=> !ot_shutdown_out)
        else $error("restart mode kept the overheat shutdown");

    c_write_taken: cover property (wr_in && cmd_in == CMD_OC_WARN_LEVEL ##1 !invalid_data_out);
    c_write_refused: cover property (invalid_data_out);
    c_restart_cycle: cover property (oc_shutdown_out ##1 !oc_shutdown_out);
    c_latched_trip: cover property (oc_trip_reg == FLR_TRIP_LATCHED && !iout_oc_fault_in);
    c_status_clear: cover property (wr_in && cmd_in == CMD_IOUT_STATUS
        ##1 iout_status_reg == STATUS_RST);

endmodule // flr_regs

// File: testbench/flr_host_model.sv
`timescale 1ns/1ps
module flr_host_model (
    input  wire logic        clk_sys_in,  // System clock
    input  wire logic [15:0] rd_data_in,  // Read data
    input  wire logic        rd_valid_in, // Read data valid
    input  wire logic        invalid_in,  // Refused value pulse
    output logic      [7:0]  cmd_out,     // Command code
    output logic             wr_out,      // Write strobe
    output logic      [15:0] wr_data_out, // Write data
    output logic             rd_out       // Read strobe
);
    initial begin
        cmd_out = 8'h00;
        wr_out = 1'b0;
        wr_data_out = 16'h0000;
        rd_out = 1'b0;
    end
    // Data inverted once released, so a stale value never looks valid
    task automatic put(input logic [7:0] c, input logic [15:0] d, input logic w);
        @(posedge clk_sys_in);
        #1;
        cmd_out = c;
        wr_data_out = d;
        wr_out = w;
        rd_out = !w;
        @(posedge clk_sys_in);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wr_data_out = ~d;
    endtask
    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d, output logic bad);
        put(c, d, 1'b1);
        bad = 1'b0;
        repeat (3) begin
            bad |= (invalid_in === 1'b1);
            @(posedge clk_sys_in);
            #1;
        end
    endtask
    task automatic rd_cmd(input logic [7:0] c, output logic [15:0] q);
        put(c, 16'hffff, 1'b0);
        q = (rd_valid_in === 1'b1) ? rd_data_in : 16'hxxxx;
    endtask
endmodule // flr_host_model

// File: testbench/test_flr_regs.sv
`timescale 1ns/1ps
module test_flr_regs;
    import flr_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wp = 1'b0, rv, inv, wr, rd;
    logic [9:0] ev = 10'h000;
    logic [7:0] cmd;
    logic [15:0] wd, rdd, v;
    logic ce = 1'b1, fz, icmd, ocs, ots;
    logic [6:0][15:0] lv;
    int err_count = 0, checks = 0, cyc = 0;
    initial forever #5 clk = ~clk;
    flr_host_model u_host (.clk_sys_in(clk), .rd_data_in(rdd), .rd_valid_in(rv),
        .invalid_in(inv), .cmd_out(cmd), .wr_out(wr), .wr_data_out(wd), .rd_out(rd));
    flr_regs u_dut (.clk_sys_in(clk), .rst_b_in(rst_b), .clk_en_in(ce), .cmd_in(cmd),
        .wr_in(wr), .wr_data_in(wd), .rd_in(rd), .write_protect_enable_in(wp),
        .vout_ov_fault_in(ev[0]), .iout_oc_fault_in(ev[1]), .iout_oc_warn_in(ev[2]),
        .ot_fault_in(ev[3]), .input_fault_in(ev[4]), .vin_uv_fault_in(ev[5]),
        .temp_fault_in(ev[6]), .communication_fault_summary_in(ev[7]),
        .power_not_good_in(ev[8]), .output_off_in(ev[9]), .rd_data_out(rdd),
        .rd_valid_out(rv), .invalid_data_out(inv), .invalid_cmd_out(icmd),
        .oc_shutdown_out(ocs), .ot_shutdown_out(ots), .oc_fault_level_out(lv[0]),
        .oc_warn_level_out(lv[1]), .ot_fault_level_out(lv[2]), .ot_warn_level_out(lv[3]),
        .vin_ov_level_out(lv[4]), .turn_on_delay_out(lv[5]), .rise_time_out(lv[6]));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] e);
        u_host.rd_cmd(c, v);
        chk(v, e);
    endtask
    // Write, then check the refusal flag and the value read back
    task automatic wt(input logic [7:0] c, input logic [15:0] d, input logic b,
                      input logic [15:0] e);
        logic f;
        u_host.wr_cmd(c, d, f);
        chk({15'h0000, f}, {15'h0000, b});
        rchk(c, e);
    endtask
    task automatic end_sim;
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        rchk(8'h47, 16'h00f8);
        rchk(8'h50, 16'h00b8);
        wt(8'h50, 16'h0000, 1'b0, 16'h0080);
        wt(8'h50, 16'h00ff, 1'b0, 16'h00b8);
        wt(8'h50, 16'h0028, 1'b1, 16'h00b8);
        wt(8'h47, 16'h0007, 1'b0, 16'h00c0);
        wt(8'h4a, 16'h0018, 1'b1, 16'h005a);
        wt(8'h4a, 16'h0064, 1'b1, 16'h005a);
        wt(8'h4a, 16'h0019, 1'b0, 16'h0019);
        wt(8'h46, 16'h0065, 1'b1, 16'h0064);
        wt(8'h46, 16'h0022, 1'b0, 16'h0022);
        wt(8'h4f, 16'h0019, 1'b1, 16'h007d);
        wt(8'h51, 16'h0019, 1'b0, 16'h0019);
        wt(8'h4f, 16'h008d, 1'b1, 16'h007d);
        wt(8'h4f, 16'h008c, 1'b0, 16'h008c);
        wt(8'h51, 16'h007e, 1'b1, 16'h0019);
        wt(8'h55, 16'h005b, 1'b1, 16'h0041);
        wt(8'h55, 16'h0030, 1'b0, 16'h0030);
        wt(8'h60, 16'h01f4, 1'b0, 16'h01f4);
        ce = 1'b0;
        u_host.wr_cmd(8'h60, 16'h0064, fz);
        ce = 1'b1;
        chk({15'h0000, fz}, 16'h0000);
        rchk(8'h60, 16'h01f4);
        wt(8'h61, 16'h000b, 1'b1, 16'h000c);
        wt(8'h79, 16'h1234, 1'b1, 16'h0000);
        wp = 1'b1;
        wt(8'h55, 16'h005a, 1'b0, 16'h0030);
        wp = 1'b0;
        ev = 10'h002;
        rchk(8'h7b, 16'h0080);
        rchk(8'h79, 16'h4010);
        chk({14'h0000, ocs, ots}, 16'h0002);
        ev = 10'h00c;
        wt(8'h7b, 16'h0080, 1'b0, 16'h0020);
        chk({14'h0000, ocs, ots}, 16'h0003);
        ev = 10'h001;
        rchk(8'h7a, 16'h0080);
        chk({14'h0000, ocs, ots}, 16'h0002);
        rchk(8'h79, 16'hc020);
        ev = 10'h3f0;
        wt(8'h7a, 16'h0080, 1'b0, 16'h0000);
        wt(8'h7b, 16'h0020, 1'b0, 16'h0000);
        chk({14'h0000, ocs, ots}, 16'h0000);
        rchk(8'h79, 16'h284e);
        rchk(8'h01, 16'h0000);
        chk({15'h0000, icmd}, 16'h0001);
        chk(lv[0], 16'h0022);
        chk(lv[1], 16'h0019);
        chk(lv[2], 16'h008c);
        chk(lv[3], 16'h0019);
        chk(lv[4], 16'h0030);
        chk(lv[5], 16'h01f4);
        chk(lv[6], 16'h000c);
        ev = 10'h005;
        repeat (2) @(posedge clk);
        #1 ev = 10'h000;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        rchk(8'h7a, 16'h0000);
        rchk(8'h7b, 16'h0000);
        end_sim();
    end
endmodule // test_flr_regs
